// ===== design/sfp_pkg.sv
// Shared constants and types of the serial flash pin front end.
// Assumes one 40 MHz system clock; all flash pins are asynchronous to it.
package sfp_pkg;

  // System clock rate and the minimum low time of the restart pin
  localparam int unsigned CLK_HZ               = 40_000_000;
  localparam int unsigned RESTART_PULSE_MIN_NS = 1000;
  localparam int unsigned RESTART_CYC          =
    (RESTART_PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Array geometry
  localparam int unsigned ARRAY_BYTES   = 4194304;
  localparam int unsigned BLOCK_BYTES   = 65536;
  localparam int unsigned SECTOR_BYTES  = 4096;
  localparam int unsigned PAGE_BYTES    = 256;
  localparam int unsigned SECREG_BYTES  = 256;
  localparam logic [7:0]  PARAM_TABLE   = 8'h30;
  localparam logic [7:0]  PARAM_END     = 8'h6F;

  // Instruction codes
  localparam logic [7:0] CMD_WRSR   = 8'h01;
  localparam logic [7:0] CMD_PROG   = 8'h02;
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [7:0] CMD_RDSR1  = 8'h05;
  localparam logic [7:0] CMD_RDSR2  = 8'h35;
  localparam logic [7:0] CMD_WREN   = 8'h06;
  localparam logic [7:0] CMD_SECTER = 8'h20;
  localparam logic [7:0] CMD_BLKER  = 8'hD8;
  localparam logic [7:0] CMD_CHIPER = 8'hC7;
  localparam logic [7:0] CMD_DREAD  = 8'h3B;
  localparam logic [7:0] CMD_QREAD  = 8'h6B;
  localparam logic [7:0] CMD_SREAD  = 8'h48;
  localparam logic [7:0] CMD_SPROG  = 8'h42;
  localparam logic [7:0] CMD_SERASE = 8'h44;
  localparam logic [7:0] CMD_PARAM  = 8'h5A;

  // Register offsets on the APB side
  localparam logic [7:0] OFS_STATUS1 = 8'h00;
  localparam logic [7:0] OFS_STATUS2 = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_STATE   = 8'h0C;

  // Reset values
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;

  // Manufacturer code in the parameter header, value arbitrary
  localparam logic [7:0] MAKER_CODE = 8'hA5;

  // Flash pins as seen by the block
  typedef struct packed {
    logic       csN;
    logic       sclk;
    logic [3:0] io;
  } sfp_pins_s;

  // Link protocol phases, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD  = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_DUMY = 7'b0001000,
    ST_DIN  = 7'b0010000,
    ST_DOUT = 7'b0100000,
    ST_SKIP = 7'b1000000
  } sfp_state_e;

endpackage

// ===== design/sfp_pin_map.sv
// Serial flash device: pin sampling, command front end, array and security storage.
// Assumes flash pins arrive asynchronously; APB master on ref_clk.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module sfp_pin_map
  import sfp_pkg::*;
#(
  parameter int unsigned ARRAY_AW = 22,
  parameter int unsigned RESTART_CYCLES = RESTART_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  input  wire sfp_pins_s   pinIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe
);

  localparam int unsigned ARRAY_SIZE = 2 ** ARRAY_AW; // Bytes actually stored

  sfp_pins_s     pinA_reg;       // First synchroniser stage
  sfp_pins_s     pinB_reg;       // Second synchroniser stage
  logic          sclkD_reg;      // Delayed clock for edge detect
  logic          csD_reg;        // Delayed chip select
  logic          armed_reg;      // Chip select seen high since reset
  logic [1:0]    syncOk_reg;     // Synchroniser flushed of its reset value
  logic          selected_reg;   // Inside a valid frame
  sfp_state_e    st_reg;         // Protocol phase
  logic [4:0]    bitCnt_reg;     // Rising edges within phase
  logic [7:0]    cmd_reg;        // Current instruction
  logic [23:0]   addr_reg;       // Current address
  logic [7:0]    inSh_reg;       // Input shift register
  logic          wrsrSecond_reg; // Next status byte is the second
  logic [7:0]    outSh_reg;      // Output shift register
  logic [3:0]    outCnt_reg;     // Bits still in outSh
  logic [7:0]    sr1_reg;        // Status 1 (bit0 unused, busy is live)
  logic [7:0]    sr2_reg;        // Status 2
  logic          fnSel_reg;      // io3_function_select
  logic [23:0]   erAddr_reg;     // Erase pointer
  logic [22:0]   erLeft_reg;     // Bytes left to erase
  logic          erSec_reg;      // Erase targets a security register
  logic [6:0]    rstCnt_reg;     // Restart pin low time
  logic          abort_reg;      // One-cycle restart abort
  logic [7:0]    mem [ARRAY_SIZE];   // Main array
  logic [7:0]    secMem [1024];      // Security registers, index {reg,byte}

  logic sclkRise, sclkFall, pauseAct, rise, fall, byteIn, busy, quadEn, wpN;
  logic [7:0] inByte, srcByte;
  logic [1:0] secSel;
  logic [2:0] laneW;
  logic [3:0] laneMask;

  // Parameter space contents; unwritten and reserved bytes read as erased
  function automatic logic [7:0] paramRom(input logic [7:0] a);
    case (a)
      8'h00: paramRom = 8'h53;
      8'h01: paramRom = 8'h46;
      8'h02: paramRom = 8'h44;
      8'h03: paramRom = 8'h50;
      8'h05: paramRom = 8'h01;
      8'h06: paramRom = 8'h01;
      8'h0A: paramRom = 8'h01;
      8'h0B: paramRom = 8'h09;
      8'h0C: paramRom = PARAM_TABLE;
      8'h10: paramRom = MAKER_CODE;
      8'h12: paramRom = 8'h01;
      8'h13: paramRom = 8'h04;
      8'h14: paramRom = 8'h60;
      8'h30: paramRom = 8'hE5;
      8'h31: paramRom = CMD_SECTER;
      8'h04, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15, 8'h16: paramRom = 8'h00;
      default: paramRom = 8'hFF;
    endcase
  endfunction

  // Block protection test for an array address
  function automatic logic isProt(input logic [23:0] a, input logic [7:0] s1,
                                  input logic [7:0] s2);
    logic [23:0] len;
    logic        hit;
    len = 24'h000000;
    if (s1[4:2] == 3'h7 && !s1[6]) begin
      len = 24'(ARRAY_BYTES);
    end else if (s1[4:2] != 3'h0) begin
      len = s1[6] ? 24'(SECTOR_BYTES) << (s1[4:2] > 3'h4 ? 3'h3 : s1[4:2] - 3'h1)
                  : 24'(BLOCK_BYTES) << (s1[4:2] - 3'h1);
    end
    hit = s1[5] ? (a >= 24'(ARRAY_BYTES) - len) : (a < len);
    isProt = hit ^ s2[6];
  endfunction

  assign quadEn   = sr2_reg[1];
  assign wpN      = pinB_reg.io[2];
  assign busy     = (erLeft_reg != 23'h0);
  assign secSel   = addr_reg[13:12];
  assign sclkRise = pinB_reg.sclk & ~sclkD_reg;
  assign sclkFall = ~pinB_reg.sclk & sclkD_reg;
  // Pause only when IO3 is neither data nor restart
  assign pauseAct = ~quadEn & ~fnSel_reg & ~pinB_reg.io[3] & ~pinB_reg.csN;
  assign rise     = sclkRise & selected_reg & ~pinB_reg.csN & ~pauseAct;
  assign fall     = sclkFall & selected_reg & ~pinB_reg.csN & ~pauseAct;
  assign inByte   = {inSh_reg[6:0], pinB_reg.io[0]};
  assign byteIn   = rise && bitCnt_reg[2:0] == 3'h7;

  // Lane width of the read in progress
  always_comb begin
    laneW    = 3'h1;
    laneMask = 4'b0010;
    if (cmd_reg == CMD_DREAD) begin
      laneW    = 3'h2;
      laneMask = 4'b0011;
    end else if (cmd_reg == CMD_QREAD) begin
      laneW    = 3'h4;
      laneMask = 4'b1111;
    end
  end

  // Byte source for reads
  always_comb begin
    case (cmd_reg)
      CMD_RDSR1: srcByte = {sr1_reg[7:1], busy};
      CMD_RDSR2: srcByte = sr2_reg;
      CMD_PARAM: srcByte = paramRom(addr_reg[7:0]);
      CMD_SREAD: srcByte = (secSel == 2'h0) ? paramRom(addr_reg[7:0])
                                             : secMem[{secSel, addr_reg[7:0]}];
      default:   srcByte = mem[addr_reg[ARRAY_AW-1:0]];
    endcase
  end

  // Two-stage synchroniser and edge history
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinA_reg  <= '{csN: 1'b1, sclk: 1'b0, io: 4'hF};
      pinB_reg  <= '{csN: 1'b1, sclk: 1'b0, io: 4'hF};
      sclkD_reg <= 1'b0;
      csD_reg   <= 1'b1;
    end else begin
      pinA_reg  <= pinIn;
      pinB_reg  <= pinA_reg;
      sclkD_reg <= pinB_reg.sclk;
      csD_reg   <= pinB_reg.csN;
    end
  end

  // Frame gating: arm on high chip select, open on its fall
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_reg    <= 1'b0;
      selected_reg <= 1'b0;
      syncOk_reg   <= 2'b00;
    end else begin
      // Reset value of the synchroniser is not a real high on the pin
      syncOk_reg <= {syncOk_reg[0], 1'b1};
      if (pinB_reg.csN && syncOk_reg[1]) begin
        armed_reg <= 1'b1;
      end
      if (pinB_reg.csN || abort_reg) begin
        selected_reg <= 1'b0;
      end else if (csD_reg && armed_reg) begin
        selected_reg <= 1'b1;
      end
    end
  end

  // Restart pin low-time counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rstCnt_reg <= 7'h00;
      abort_reg  <= 1'b0;
    end else begin
      abort_reg <= 1'b0;
      if (quadEn || !fnSel_reg || pinB_reg.io[3]) begin
        rstCnt_reg <= 7'h00;
      end else if (rstCnt_reg < 7'(RESTART_CYCLES)) begin
        rstCnt_reg <= rstCnt_reg + 7'h01;
        abort_reg  <= (rstCnt_reg == 7'(RESTART_CYCLES - 1));
      end
    end
  end

  // Protocol phase machine and shifters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg         <= ST_IDLE;
      bitCnt_reg     <= 5'h00;
      cmd_reg        <= 8'h00;
      addr_reg       <= 24'h000000;
      inSh_reg       <= 8'h00;
      wrsrSecond_reg <= 1'b0;
      outSh_reg      <= 8'h00;
      outCnt_reg     <= 4'h0;
    end else if (abort_reg) begin
      st_reg <= ST_SKIP;
    end else if (pinB_reg.csN) begin
      st_reg <= ST_IDLE;
    end else if (csD_reg && armed_reg) begin
      st_reg         <= ST_CMD;
      bitCnt_reg     <= 5'h00;
      wrsrSecond_reg <= 1'b0;
      outCnt_reg     <= 4'h0;
    end else if (rise) begin
      // Input side on rising clock
      inSh_reg   <= inByte;
      bitCnt_reg <= bitCnt_reg + 5'h01;
      case (st_reg)
        ST_CMD: begin
          if (byteIn) begin
            cmd_reg    <= inByte;
            bitCnt_reg <= 5'h00;
            if (busy && inByte != CMD_RDSR1) begin
              st_reg <= ST_SKIP;
            end else begin
              case (inByte)
                CMD_RDSR1, CMD_RDSR2: st_reg <= ST_DOUT;
                CMD_WRSR: st_reg <= (sr1_reg[1] && !(sr1_reg[7] && !wpN && !quadEn))
                                    ? ST_DIN : ST_SKIP;
                CMD_QREAD: st_reg <= quadEn ? ST_ADDR : ST_SKIP;
                CMD_READ, CMD_DREAD, CMD_PARAM, CMD_SREAD, CMD_PROG,
                CMD_SECTER, CMD_BLKER, CMD_SPROG, CMD_SERASE: st_reg <= ST_ADDR;
                default: st_reg <= ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          addr_reg <= {addr_reg[22:0], pinB_reg.io[0]};
          if (bitCnt_reg == 5'd23) begin
            bitCnt_reg <= 5'h00;
            case (cmd_reg)
              CMD_READ: st_reg <= ST_DOUT;
              CMD_DREAD, CMD_QREAD, CMD_PARAM, CMD_SREAD: st_reg <= ST_DUMY;
              CMD_PROG: st_reg <= (sr1_reg[1] && !isProt({addr_reg[22:0],
                                   pinB_reg.io[0]}, sr1_reg, sr2_reg)) ? ST_DIN : ST_SKIP;
              CMD_SPROG: st_reg <= (sr1_reg[1] && addr_reg[12:11] != 2'h0
                                    && !sr2_reg[3'h2 + 3'(addr_reg[12:11])])
                                   ? ST_DIN : ST_SKIP;
              default: st_reg <= ST_SKIP;
            endcase
          end
        end
        ST_DUMY: begin
          if (bitCnt_reg == 5'd7) begin
            st_reg     <= ST_DOUT;
            bitCnt_reg <= 5'h00;
          end
        end
        ST_DIN: begin
          if (byteIn) begin
            bitCnt_reg <= 5'h00;
            // Programming stays inside one page
            addr_reg <= {addr_reg[23:8], addr_reg[7:0] + 8'h01};
            if (cmd_reg == CMD_WRSR) begin
              wrsrSecond_reg <= 1'b1;
              if (wrsrSecond_reg) begin
                st_reg <= ST_SKIP;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end else if (fall && st_reg == ST_DOUT) begin
      // Output side on falling clock, byte reloaded when empty
      if (outCnt_reg == 4'h0) begin
        outSh_reg  <= srcByte << laneW;
        outCnt_reg <= 4'h8 - 4'(laneW);
        addr_reg   <= addr_reg + 24'h000001;
      end else begin
        outSh_reg  <= outSh_reg << laneW;
        outCnt_reg <= outCnt_reg - 4'(laneW);
      end
    end
  end

  // Data pins: value moves only on falling clock, float when not reading
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ioOut <= 4'h0;
      ioOe  <= 4'h0;
    end else begin
      if (st_reg == ST_DOUT && !pinB_reg.csN && selected_reg && !pauseAct && !abort_reg) begin
        ioOe <= laneMask;
      end else begin
        ioOe <= 4'h0;
      end
      if (fall && st_reg == ST_DOUT) begin
        case (laneW)
          3'h2:    ioOut <= {2'b00, (outCnt_reg == 4'h0) ? srcByte[7:6] : outSh_reg[7:6]};
          3'h4:    ioOut <= (outCnt_reg == 4'h0) ? srcByte[7:4] : outSh_reg[7:4];
          default: ioOut <= {2'b00, (outCnt_reg == 4'h0) ? srcByte[7] : outSh_reg[7], 1'b0};
        endcase
      end
    end
  end

  // Status registers, written by the link and by APB
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sr1_reg   <= SR1_RESET;
      sr2_reg   <= SR2_RESET;
      fnSel_reg <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite) begin
        if (paddr == OFS_STATUS1) begin
          sr1_reg <= {pwdata[7:2], sr1_reg[1:0]};
        end
        if (paddr == OFS_STATUS2) begin
          sr2_reg <= pwdata[7:0] | {2'b00, sr2_reg[5:2], 2'b00};
        end
        if (paddr == OFS_CONFIG) begin
          fnSel_reg <= pwdata[0];
        end
      end
      if (abort_reg) begin
        sr1_reg[1] <= 1'b0;
      end else if (rise && st_reg == ST_CMD && byteIn && inByte == CMD_WREN && !busy) begin
        sr1_reg[1] <= 1'b1;
      end else if (byteIn && st_reg == ST_DIN && cmd_reg == CMD_WRSR) begin
        if (wrsrSecond_reg) begin
          sr2_reg    <= inByte | {2'b00, sr2_reg[5:2], 2'b00};
          sr1_reg[1] <= 1'b0;
        end else begin
          sr1_reg <= {inByte[7:2], sr1_reg[1:0]};
        end
      end else if (pinB_reg.csN && !csD_reg && st_reg != ST_CMD) begin
        if (cmd_reg == CMD_PROG || cmd_reg == CMD_SPROG || cmd_reg == CMD_SECTER
            || cmd_reg == CMD_BLKER || cmd_reg == CMD_CHIPER || cmd_reg == CMD_SERASE) begin
          sr1_reg[1] <= 1'b0;
        end
      end
    end
  end

  // Erase engine: one byte per cycle, runs on after deselection
  always_ff @(posedge ref_clk) begin
    if (rst || abort_reg) begin
      erAddr_reg <= 24'h000000;
      erLeft_reg <= 23'h000000;
      erSec_reg  <= 1'b0;
    end else if (busy) begin
      erAddr_reg <= erAddr_reg + 24'h000001;
      erLeft_reg <= erLeft_reg - 23'h000001;
    end else if (rise && sr1_reg[1] && st_reg == ST_CMD && byteIn && inByte == CMD_CHIPER
                 && sr1_reg[4:2] == 3'h0 && !sr2_reg[6]) begin
      erAddr_reg <= 24'h000000;
      erLeft_reg <= 23'(ARRAY_SIZE);
      erSec_reg  <= 1'b0;
    end else if (rise && sr1_reg[1] && st_reg == ST_ADDR && bitCnt_reg == 5'd23) begin
      if (cmd_reg == CMD_SECTER && !isProt({addr_reg[22:0], pinB_reg.io[0]}, sr1_reg,
                                           sr2_reg)) begin
        erAddr_reg <= {addr_reg[22:11], 12'h000};
        erLeft_reg <= 23'(SECTOR_BYTES);
        erSec_reg  <= 1'b0;
      end else if (cmd_reg == CMD_BLKER && !isProt({addr_reg[22:0], pinB_reg.io[0]},
                                                   sr1_reg, sr2_reg)) begin
        erAddr_reg <= {addr_reg[22:15], 16'h0000};
        erLeft_reg <= 23'(BLOCK_BYTES);
        erSec_reg  <= 1'b0;
      end else if (cmd_reg == CMD_SERASE && addr_reg[12:11] != 2'h0
                   && !sr2_reg[3'h2 + 3'(addr_reg[12:11])]) begin
        erAddr_reg <= {addr_reg[22:11], 12'h000};
        erLeft_reg <= 23'(SECREG_BYTES);
        erSec_reg  <= 1'b1;
      end
    end
  end

  // Storage writes: programming clears bits only, erase sets them
  always_ff @(posedge ref_clk) begin
    if (busy) begin
      if (erSec_reg) begin
        secMem[{erAddr_reg[13:12], erAddr_reg[7:0]}] <= 8'hFF;
      end else begin
        mem[erAddr_reg[ARRAY_AW-1:0]] <= 8'hFF;
      end
    end else if (byteIn && st_reg == ST_DIN && !pinB_reg.csN) begin
      if (cmd_reg == CMD_PROG) begin
        mem[addr_reg[ARRAY_AW-1:0]] <= mem[addr_reg[ARRAY_AW-1:0]] & inByte;
      end else if (cmd_reg == CMD_SPROG) begin
        secMem[{secSel, addr_reg[7:0]}] <= secMem[{secSel, addr_reg[7:0]}] & inByte;
      end
    end
  end

  // APB slave: one wait-free access cycle, registered answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          OFS_STATUS1: prdata <= {24'h000000, sr1_reg[7:1], busy};
          OFS_STATUS2: prdata <= {24'h000000, sr2_reg};
          OFS_CONFIG:  prdata <= {31'h00000000, fnSel_reg};
          OFS_STATE:   prdata <= {22'h000000, pauseAct, selected_reg, armed_reg, st_reg};
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  sequence s_frameOpen;
    csD_reg && !pinB_reg.csN && armed_reg;
  endsequence

  a_deselect_float: assert property (@(posedge ref_clk) disable iff (rst)
    pinB_reg.csN |=> ioOe == 4'h0) else $error("outputs driven while deselected");
  a_pause_float: assert property (@(posedge ref_clk) disable iff (rst)
    pauseAct |=> ioOe == 4'h0) else $error("outputs driven during pause");
  a_pause_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    (pauseAct && !abort_reg && !pinB_reg.csN && !(csD_reg && armed_reg))
    |=> $stable(bitCnt_reg) && $stable(st_reg)) else $error("counter moved in pause");
  a_fall_drive: assert property (@(posedge ref_clk) disable iff (rst)
    !$stable(ioOut) |-> $past(fall)) else $error("output changed off falling edge");
  a_rise_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (rise && st_reg == ST_ADDR) |=> addr_reg[0] == $past(pinB_reg.io[0]))
    else $error("address bit not sampled on rise");
  a_frame_arm: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_IDLE && !armed_reg) |=> st_reg != ST_CMD)
    else $error("frame opened without chip-select fall");
  a_frame_open: assert property (@(posedge ref_clk) disable iff (rst)
    s_frameOpen and !abort_reg |=> st_reg == ST_CMD ##1 selected_reg || pinB_reg.csN)
    else $error("frame not opened");
  a_restart_abort: assert property (@(posedge ref_clk) disable iff (rst)
    (fnSel_reg && !quadEn && !pinB_reg.io[3] && rstCnt_reg == 7'(RESTART_CYCLES - 1))
    |=> abort_reg ##1 (!busy && st_reg == ST_SKIP))
    else $error("restart did not abort");
  a_quad_no_restart: assert property (@(posedge ref_clk) disable iff (rst)
    quadEn |-> rstCnt_reg == 7'h00 && !pauseAct) else $error("IO3 control in quad mode");
  a_program_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (byteIn && st_reg == ST_DIN && cmd_reg == CMD_PROG && !busy && !pinB_reg.csN)
    |=> (mem[$past(addr_reg[ARRAY_AW-1:0])] & ~$past(mem[addr_reg[ARRAY_AW-1:0]])) == 8'h00)
    else $error("program set a bit");

endmodule

// ===== verif/sfp_host_model.sv
// Host side of the flash link: select, link clock, io0 out, one to four lanes in.
// Assumes the bench clock; lane levels resolve from the device enables.
`timescale 1ns/1ps
module sfp_host_model
  import sfp_pkg::*;
(
  // Clock and device lanes
  input  wire logic       ref_clk,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe,
  // Resolved pins
  output sfp_pins_s       pins
);
  logic [3:0] hostIo = 4'hF;  // Host lane levels, protect and pause idle high
  logic       csN    = 1'b1;  // Select, idle high
  logic       sclk   = 1'b0;  // Link clock, still between frames
  // Released io1 shows the inverse of its last bit so a stale bit cannot match
  always_comb begin
    pins.csN = csN;
    pins.sclk = sclk;
    for (int i = 0; i < 4; i++) begin
      pins.io[i] = ioOe[i] ? ioOut[i] : (i == 1) ? ~ioOut[i] : hostIo[i];
    end
  end
  // Half a 200 ns link period
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask
  // Every frame opens with a select fall
  task automatic frame(input logic on);
    half();
    csN <= ~on;
    half();
  endtask
  // Byte out MSB first, set up before the rise
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      hostIo[0] <= b[i];
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
  // Byte in MSB first, taken just before the rise
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half();
      b[i] = pins.io[1];
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
  // Byte in over w lanes, highest lane carries the highest bit
  task automatic getn(input int w, output logic [7:0] b);
    for (int i = 7; i >= 0; i -= w) begin
      half();
      for (int j = 0; j < w; j++) begin
        b[i - j] = pins.io[w - 1 - j];
      end
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
endmodule

// ===== verif/sfp_pin_map_tb.sv
// Bench for the flash pin map: APB registers and link transfers.
// Assumes the host model drives the flash pins.
`timescale 1ns/1ps
module sfp_pin_map_tb
  import sfp_pkg::*;
;
  logic        ref_clk = 1'b0;  // 40 MHz
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00, b;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0]  ioOut, ioOe;
  sfp_pins_s   pins;
  int          failures, samples_checked, cycles;
  always #12.5 ref_clk = ~ref_clk;
  sfp_pin_map #(.ARRAY_AW(14)) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pins), .ioOut(ioOut), .ioOe(ioOe));
  sfp_host_model host (.ref_clk(ref_clk), .ioOut(ioOut), .ioOe(ioOe), .pins(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll the busy bit until the internal cycle ends
  task automatic idle();
    apb(1'b0, OFS_STATUS1, 32'h0);
    while (r[0] !== 1'b0) begin
      apb(1'b0, OFS_STATUS1, 32'h0);
    end
  endtask
  // Write enable, then a two-byte status write
  task automatic wrsr(input logic [7:0] s1);
    host.frame(1'b1);
    host.put(CMD_WREN);
    host.frame(1'b0);
    host.frame(1'b1);
    host.put(CMD_WRSR);
    host.put(s1);
    host.put(8'h00);
    host.frame(1'b0);
  endtask
  // Command with a 24-bit address, frame left open
  task automatic go(input logic [7:0] c, input logic [23:0] a);
    host.frame(1'b1);
    host.put(c);
    host.put(a[23:16]);
    host.put(a[15:8]);
    host.put(a[7:0]);
  endtask
  // Write enable, then erase or one-byte program, then wait
  task automatic wop(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
    host.frame(1'b1);
    host.put(CMD_WREN);
    host.frame(1'b0);
    go(c, a);
    if (c == CMD_PROG) host.put(d);
    host.frame(1'b0);
    idle();
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, OFS_CONFIG, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    wop(CMD_SECTER, 24'h0, 8'h00);
    wop(CMD_PROG, 24'h10, 8'hF0);
    wop(CMD_PROG, 24'h10, 8'h3C);
    wop(CMD_PROG, 24'h11, 8'hA5);
    go(CMD_READ, 24'h10);
    host.get(b);
    chk({24'h0, b}, 32'h30);
    chk({28'h0, ioOe}, 32'h2);
    // Pause with clocks running: lanes float, position frozen
    host.half();
    host.hostIo[3] <= 1'b0;
    host.put(8'h00);
    chk({28'h0, ioOe}, 32'h0);
    host.half();
    host.hostIo[3] <= 1'b1;
    host.get(b);
    chk({24'h0, b}, 32'hA5);
    host.get(b);
    chk({24'h0, b}, 32'hFF);
    host.frame(1'b0);
    chk({28'h0, ioOe}, 32'h0);
    // Guard bit with the protect pin low refuses a status write
    apb(1'b1, OFS_STATUS1, 32'h80);
    host.hostIo[2] <= 1'b0;
    wrsr(8'h1C);
    apb(1'b0, OFS_STATUS1, 32'h0);
    chk(r, 32'h82);
    host.hostIo[2] <= 1'b1;
    wrsr(8'h00);
    apb(1'b0, OFS_STATUS1, 32'h0);
    chk(r, 32'h0);
    // Dual, quad and parameter space reads
    go(CMD_DREAD, 24'h10);
    host.put(8'h00);
    host.getn(2, b);
    chk({24'h0, b}, 32'h30);
    host.frame(1'b0);
    apb(1'b1, OFS_STATUS2, 32'h2);
    go(CMD_QREAD, 24'h11);
    host.put(8'h00);
    host.getn(4, b);
    chk({24'h0, b}, 32'hA5);
    host.frame(1'b0);
    apb(1'b1, OFS_STATUS2, 32'h0);
    go(CMD_PARAM, 24'h0);
    host.put(8'h00);
    host.get(b);
    chk({24'h0, b}, 32'h53);
    host.frame(1'b0);
    // Restart pin held low aborts a running erase
    apb(1'b1, OFS_CONFIG, 32'h1);
    host.frame(1'b1);
    host.put(CMD_WREN);
    host.frame(1'b0);
    go(CMD_SECTER, 24'h1000);
    host.frame(1'b0);
    host.hostIo[3] <= 1'b0;
    repeat (50) @(posedge ref_clk);
    host.hostIo[3] <= 1'b1;
    apb(1'b0, OFS_STATUS1, 32'h0);
    chk(r, 32'h0);
    // Select held low across a reset: no frame without a fall
    host.csN <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    host.put(CMD_RDSR1);
    host.half();
    chk({28'h0, ioOe}, 32'h0);
    give_verdict();
  end
endmodule
